// ### shared/crbm_consts.vh
`ifndef CRBM_CONSTS_VH
`define CRBM_CONSTS_VH
// Register byte offsets
`define CRBM_OFF_CTRL 12'h000
`define CRBM_OFF_TXSEL 12'h004
`define CRBM_OFF_FEXT 12'h008
`define CRBM_OFF_FEN 12'h00c
`define CRBM_OFF_FBUF0 12'h010
`define CRBM_OFF_FBUF1 12'h014
`define CRBM_OFF_STAT 12'h018
// Buffer window: base + buffer * 0x40 + byte * 4
`define CRBM_BUF_BASE 4'h1
`define CRBM_BUF_BYTES 4'he
`define CRBM_ASM_BYTES 13
// Control register fields
`define CRBM_MODE_LSB 0
`define CRBM_WM_BIT 2
`define CRBM_CAP_BIT 3
`define CRBM_ROLL_BIT 4
`define CRBM_RXIE_BIT 5
`define CRBM_RXM0_LSB 6
`define CRBM_ACCEPT_ALL_BIT_LSB 8
`define CRBM_ALL_BIT 10
`define CRBM_MEXT_EN_BIT 11
`define CRBM_MEXT_VAL_BIT 12
// Status register fields
`define CRBM_ICODE_LSB 8
`define CRBM_RPTR_LSB 16
`define CRBM_WPTR_LSB 20
// Operating modes
`define CRBM_MODE_FIXED 2'h0
`define CRBM_MODE_FLEX 2'h1
`define CRBM_MODE_FIFO 2'h2
// Receive modes
`define CRBM_RXM_ALL 2'h3
// Codes and positions
`define CRBM_ICODE_FIFO 5'h10
`define CRBM_ROLL_HIT_BASE 4'h6
`define CRBM_EXT_BIT 3
`define CRBM_STD_ID_LOW_IDX 1
`define CRBM_WM_LOW 4'h1
`define CRBM_WM_HIGH 4'h4
// Reset values
`define CRBM_CTRL_RST 13'h0000
`endif

// ### core/crbm_rx_buffer_manager.v
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "crbm_consts.vh"
module crbm_rx_buffer_manager (
  input wire ref_clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire asm_we,
  input wire [3:0] asm_addr,
  input wire [7:0] asm_data,
  input wire frame_ok,
  input wire frame_err,
  input wire frame_ext,
  input wire frame_rtr,
  input wire [15:0] filter_match,
  output reg rx_irq,
  output reg wm_irq,
  output reg capture_pulse
);

  // Lowest set bit of a filter vector, zero when none
  function [4:0] crbm_lowest;
    input [15:0] v;
    integer k;
    begin
      crbm_lowest = 5'h00;
      for (k = 15; k >= 0; k = k - 1) begin
        if (v[k]) begin
          crbm_lowest = k[4:0];
        end
      end
    end
  endfunction

  // Identifier type check against a receive mode
  function crbm_ext_ok;
    input [1:0] receive_mode_field;
    input sel;
    input ext;
    begin
      case (receive_mode_field)
        2'h0: crbm_ext_ok = (sel == ext);
        2'h1: crbm_ext_ok = !ext && !sel;
        2'h2: crbm_ext_ok = ext && sel;
        default: crbm_ext_ok = 1'b1;
      endcase
    end
  endfunction

  reg [12:0] ctrl_reg;
  reg [5:0] txsel_reg;
  reg [15:0] fext_reg;
  reg [15:0] fen_reg;
  reg [63:0] fbuf_reg;
  reg [7:0] full_reg;
  reg [7:0] full_next;
  reg [4:0] icode_reg;
  reg [3:0] rptr_reg;
  reg [2:0] wptr_reg;
  reg [7:0] asm_mem [0:12];
  reg [7:0] buf_mem [0:103];
  reg [4:0] hit_mem [0:7];
  reg [7:0] rtr_reg;
  integer i;
  integer j;

  wire [1:0] mode = ctrl_reg[`CRBM_MODE_LSB +: 2];
  wire [1:0] rxm0 = ctrl_reg[`CRBM_RXM0_LSB +: 2];
  wire [1:0] accept_all_bit = ctrl_reg[`CRBM_ACCEPT_ALL_BIT_LSB +: 2];
  wire accept_all = ctrl_reg[`CRBM_ALL_BIT];
  wire fixed_mode = (mode == `CRBM_MODE_FIXED);
  wire fifo_mode = (mode == `CRBM_MODE_FIFO);
  wire [7:0] rx_buf = {~txsel_reg, 2'b11};
  wire [1:0] rxm_flex;
  wire [15:0] elig;
  wire [127:0] asg;

  // Flexible receive mode from accept-all and mask extension bits
  // derived receive mode
  assign rxm_flex = accept_all ? `CRBM_RXM_ALL :
    ctrl_reg[`CRBM_MEXT_EN_BIT] ? (ctrl_reg[`CRBM_MEXT_VAL_BIT] ? 2'h2 : 2'h1) : 2'h0;

  // Per-filter eligibility and buffer association
  genvar f;
  genvar b;
  generate
    for (f = 0; f < 16; f = f + 1) begin : g_filt
      if (f < 2) begin : g_b0
        assign elig[f] = filter_match[f] & (fixed_mode ?
          crbm_ext_ok(rxm0, fext_reg[f], frame_ext) :
          fen_reg[f] & crbm_ext_ok(rxm_flex, fext_reg[f], frame_ext));
      end else if (f < 6) begin : g_b1
        assign elig[f] = filter_match[f] & (fixed_mode ?
          crbm_ext_ok(accept_all_bit, fext_reg[f], frame_ext) :
          fen_reg[f] & crbm_ext_ok(rxm_flex, fext_reg[f], frame_ext));
      end else begin : g_bx
        assign elig[f] = filter_match[f] & !fixed_mode & fen_reg[f] &
          crbm_ext_ok(rxm_flex, fext_reg[f], frame_ext);
      end
      for (b = 0; b < 8; b = b + 1) begin : g_asg
        assign asg[b * 16 + f] = (fbuf_reg[f * 4 +: 4] == b);
      end
    end
  endgenerate

  // FIFO depth, occupancy and free count
  reg [3:0] depth;
  reg [3:0] occ;
  reg [3:0] empty_cnt;
  reg run;
  always @* begin
    depth = 4'h2;
    occ = 4'h0;
    run = 1'b1;
    for (i = 0; i < 6; i = i + 1) begin
      if (run && !txsel_reg[i]) begin
        depth = depth + 4'h1;
      end else begin
        run = 1'b0;
      end
    end
    for (i = 0; i < 8; i = i + 1) begin
      if (i < depth && full_reg[i]) begin
        occ = occ + 4'h1;
      end
    end
    empty_cnt = depth - occ;
  end

  // Store decision for the frame offered this cycle
  reg st_go;
  reg [2:0] st_buf;
  reg [4:0] st_hit;
  reg a0;
  reg a1;
  reg tx_hit;
  reg take;
  reg [4:0] h0;
  always @* begin
    st_go = 1'b0;
    st_buf = 3'h0;
    st_hit = 5'h00;
    tx_hit = 1'b0;
    take = 1'b0;
    // errored frames only in accept-all receive mode
    a0 = (frame_ok & (|elig[1:0])) | ((frame_ok | frame_err) & (rxm0 == `CRBM_RXM_ALL));
    a1 = (frame_ok & (|elig[5:2])) | ((frame_ok | frame_err) & (accept_all_bit == `CRBM_RXM_ALL));
    h0 = crbm_lowest({14'h0000, elig[1:0]});
    if (fixed_mode) begin
      if (a0 && !full_reg[0]) begin
        st_go = 1'b1;
        st_hit = h0;
      end else if (a0 && ctrl_reg[`CRBM_ROLL_BIT] && !full_reg[1]) begin
        st_go = 1'b1;
        st_buf = 3'h1;
        st_hit = {1'b0, `CRBM_ROLL_HIT_BASE + {3'h0, h0[0]}};
      end else if (a1 && !full_reg[1]) begin
        st_go = 1'b1;
        st_buf = 3'h1;
        st_hit = crbm_lowest({10'h000, elig[5:2], 2'b00});
      end
    end else if (fifo_mode) begin
      // any enabled filter, slot at the write pointer if it is free
      take = (frame_ok & (|elig)) | ((frame_ok | frame_err) & accept_all);
      if (take && !full_reg[wptr_reg]) begin
        st_go = 1'b1;
        st_buf = wptr_reg;
        st_hit = crbm_lowest(elig);
      end
    end else begin
      for (j = 0; j < 8; j = j + 1) begin
        if (!rx_buf[j] && (|(elig & asg[j * 16 +: 16]))) begin
          tx_hit = 1'b1;
        end
      end
      for (j = 7; j >= 0; j = j - 1) begin
        if (rx_buf[j] && !full_reg[j] &&
            (((frame_ok | frame_err) & accept_all) || (frame_ok && |(elig & asg[j * 16 +: 16])))) begin
          st_go = 1'b1;
          st_buf = j[2:0];
          st_hit = crbm_lowest(elig & asg[j * 16 +: 16]);
        end
      end
      if (tx_hit && !accept_all) begin
        st_go = 1'b0;
      end
    end
  end

  // APB phase decode
  wire setup = psel & ~penable;
  wire wr = psel & penable & pready & pwrite;
  wire in_buf = (paddr[11:8] == `CRBM_BUF_BASE) || (paddr[11:8] == `CRBM_BUF_BASE + 4'h1);
  // Buffer window starts at slot four of the 0x40 grid, so rebase the slot
  wire [3:0] buf_slot = paddr[9:6] - 4'h4;
  wire [2:0] rd_buf = buf_slot[2:0];
  wire [3:0] rd_idx = paddr[5:2];
  wire [7:0] clr = (wr && paddr == `CRBM_OFF_STAT) ? pwdata[7:0] : 8'h00;
  wire [7:0] set_vec = st_go ? (8'h01 << st_buf) : 8'h00;
  reg [31:0] rdata;
  reg mapped;

  // Read data mux
  always @* begin
    rdata = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      `CRBM_OFF_CTRL: rdata = {19'h00000, ctrl_reg};
      `CRBM_OFF_TXSEL: rdata = {26'h0000000, txsel_reg};
      `CRBM_OFF_FEXT: rdata = {16'h0000, fext_reg};
      `CRBM_OFF_FEN: rdata = {16'h0000, fen_reg};
      `CRBM_OFF_FBUF0: rdata = fbuf_reg[31:0];
      `CRBM_OFF_FBUF1: rdata = fbuf_reg[63:32];
      `CRBM_OFF_STAT: rdata = {9'h000, wptr_reg, rptr_reg, 3'h0, icode_reg, full_reg};
      default: begin
        if (in_buf && paddr[1:0] == 2'b00 && rd_idx < `CRBM_BUF_BYTES) begin
          if (rd_idx == 4'h0) begin
            rdata = {24'h000000, full_reg[rd_buf], 1'b0, rtr_reg[rd_buf], hit_mem[rd_buf]};
          end else begin
            rdata = {24'h000000, buf_mem[rd_buf * 13 + rd_idx - 1]};
          end
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end

  // Full flags: a store wins over a firmware clear
  always @* begin
    // set on store, cleared by firmware
    full_next = (full_reg & ~clr) | set_vec;
  end

  // APB slave outputs, one access-phase cycle
  always @(posedge ref_clk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= rdata;
      end
    end
  end

  // Configuration registers
  always @(posedge ref_clk) begin
    if (reset) begin
      ctrl_reg <= `CRBM_CTRL_RST;
      txsel_reg <= 6'h00;
      fext_reg <= 16'h0000;
      fen_reg <= 16'h0000;
      fbuf_reg <= 64'h0000_0000_0000_0000;
    end else if (wr) begin
      case (paddr)
        `CRBM_OFF_CTRL: ctrl_reg <= pwdata[12:0];
        `CRBM_OFF_TXSEL: txsel_reg <= pwdata[5:0];
        `CRBM_OFF_FEXT: fext_reg <= pwdata[15:0];
        `CRBM_OFF_FEN: fen_reg <= pwdata[15:0];
        `CRBM_OFF_FBUF0: fbuf_reg[31:0] <= pwdata;
        `CRBM_OFF_FBUF1: fbuf_reg[63:32] <= pwdata;
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // Assembly buffer filled by the protocol engine
  always @(posedge ref_clk) begin
    if (reset) begin
      for (i = 0; i < `CRBM_ASM_BYTES; i = i + 1) begin
        asm_mem[i] <= 8'h00;
      end
    end else if (asm_we && asm_addr < `CRBM_ASM_BYTES) begin
      asm_mem[asm_addr] <= asm_data;
    end
  end

  // Buffer contents, flags and FIFO pointers
  always @(posedge ref_clk) begin
    if (reset) begin
      for (i = 0; i < 104; i = i + 1) begin
        buf_mem[i] <= 8'h00;
      end
      for (i = 0; i < 8; i = i + 1) begin
        hit_mem[i] <= 5'h00;
      end
      rtr_reg <= 8'h00;
      full_reg <= 8'h00;
      icode_reg <= 5'h00;
      rptr_reg <= 4'h0;
      wptr_reg <= 3'h0;
    end else begin
      full_reg <= full_next;
      if (st_go) begin
        for (i = 0; i < `CRBM_ASM_BYTES; i = i + 1) begin
          buf_mem[st_buf * 13 + i] <= asm_mem[i];
        end
        buf_mem[st_buf * 13 + `CRBM_STD_ID_LOW_IDX][`CRBM_EXT_BIT] <= frame_ext;
        hit_mem[st_buf] <= fixed_mode ? {1'b0, st_hit[3:0]} : st_hit;
        rtr_reg[st_buf] <= frame_rtr;
      end
      if (st_go && fifo_mode) begin
        icode_reg <= `CRBM_ICODE_FIFO;
        wptr_reg <= ({1'b0, wptr_reg} + 4'h1 >= depth) ? 3'h0 : wptr_reg + 3'h1;
      end
      if (fifo_mode && clr[rptr_reg[2:0]] && !set_vec[rptr_reg[2:0]]) begin
        rptr_reg <= (rptr_reg + 4'h1 >= depth) ? 4'h0 : rptr_reg + 4'h1;
      end
    end
  end

  // Event outputs
  always @(posedge ref_clk) begin
    if (reset) begin
      rx_irq <= 1'b0;
      wm_irq <= 1'b0;
      capture_pulse <= 1'b0;
    end else begin
      rx_irq <= st_go & ctrl_reg[`CRBM_RXIE_BIT];
      // free count reaches the watermark level
      wm_irq <= st_go & fifo_mode & (empty_cnt - 4'h1 ==
        (ctrl_reg[`CRBM_WM_BIT] ? `CRBM_WM_HIGH : `CRBM_WM_LOW));
      capture_pulse <= st_go & ctrl_reg[`CRBM_CAP_BIT];
    end
  end

endmodule // crbm_rx_buffer_manager

// ### dv/crbm_rx_monitor.sv
`timescale 1ns/1ps
`include "crbm_consts.vh"
module crbm_rx_monitor (
  input wire ref_clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire frame_ok,
  input wire frame_err,
  input wire rx_irq,
  input wire wm_irq,
  input wire capture_pulse
);
  reg [12:0] ctrl_q;
  // Shadow of the control word as written over the bus
  always @(posedge ref_clk) begin
    if (reset) begin
      ctrl_q <= 13'h0000;
    end else if (psel && penable && pready && pwrite && paddr == `CRBM_OFF_CTRL) begin
      ctrl_q <= pwdata[12:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_access;
    psel && penable;
  endsequence
  ready_after_setup_a: assert property (apb_setup ##1 apb_access |-> pready)
    else $error("no ready in access cycle");
  ready_needs_setup_a: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  ready_one_cycle_a: assert property (pready |=> !pready) else $error("ready held");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  err_unmapped_a: assert property (apb_setup and paddr == 12'h01c |=> pslverr)
    else $error("unmapped access accepted");
  rx_irq_cause_a: assert property (rx_irq |-> ctrl_q[5] && $past(frame_ok || frame_err))
    else $error("receive pulse without stored frame");
  cap_cause_a: assert property (capture_pulse |-> ctrl_q[3] && $past(frame_ok || frame_err))
    else $error("capture pulse without frame");
  wm_fifo_only_a: assert property (wm_irq |-> ctrl_q[1:0] == 2'h2 && $past(frame_ok))
    else $error("watermark outside fifo store");
  reset_quiet_a: assert property (disable iff (1'b0) reset |=> !pready && !rx_irq && !wm_irq)
    else $error("output active in reset");
endmodule // crbm_rx_monitor
bind crbm_rx_buffer_manager crbm_rx_monitor i_crbm_rx_monitor (
  .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .frame_ok(frame_ok), .frame_err(frame_err), .rx_irq(rx_irq), .wm_irq(wm_irq),
  .capture_pulse(capture_pulse));

// ### dv/crbm_engine_model.sv
`timescale 1ns/1ps
module crbm_engine_model (
  input wire ref_clk,
  output logic asm_we,
  output logic [3:0] asm_addr,
  output logic [7:0] asm_data,
  output logic frame_ok,
  output logic frame_err,
  output logic frame_ext,
  output logic frame_rtr,
  output logic [15:0] filter_match
);
  initial begin
    {asm_we, frame_ok, frame_err, frame_ext, frame_rtr} = 5'h00;
    asm_addr = 4'h0;
    asm_data = 8'h00;
    filter_match = 16'h0000;
  end
  // Assemble 13 bytes, then flag the frame with its match vector
  task automatic send(input [7:0] base, input ext, input rtr, input [15:0] hit);
    int i;
    for (i = 0; i < 13; i++) begin
      @(posedge ref_clk);
      asm_we <= 1'b1;
      asm_addr <= i[3:0];
      asm_data <= base + i[7:0];
    end
    @(posedge ref_clk);
    asm_we <= 1'b0;
    frame_ok <= 1'b1;
    frame_ext <= ext;
    frame_rtr <= rtr;
    filter_match <= hit;
    // Qualifiers are no longer valid: show their inverse
    @(posedge ref_clk);
    frame_ok <= 1'b0;
    frame_ext <= ~ext;
    frame_rtr <= ~rtr;
    filter_match <= ~hit;
    asm_data <= ~asm_data;
  endtask
endmodule // crbm_engine_model

// ### dv/crbm_rx_buffer_manager_tb.sv
`timescale 1ns/1ps
`include "crbm_consts.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module crbm_rx_buffer_manager_tb;
  logic ref_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic frame_err = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, asm_we, frame_ok, frame_ext, frame_rtr, rx_irq, wm_irq, cap;
  logic [3:0] asm_addr;
  logic [7:0] asm_data;
  logic [15:0] filter_match;
  int errors = 0, num_checks = 0, irq_n = 0, cap_n = 0, wm_n = 0, cyc = 0;
  logic lerr;
  always #20 ref_clk = ~ref_clk;
  crbm_engine_model i_crbm_engine_model (.ref_clk(ref_clk), .asm_we(asm_we),
    .asm_addr(asm_addr), .asm_data(asm_data), .frame_ok(frame_ok), .frame_err(),
    .frame_ext(frame_ext), .frame_rtr(frame_rtr), .filter_match(filter_match));
  crbm_rx_buffer_manager i_crbm_rx_buffer_manager (.ref_clk(ref_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .asm_we(asm_we),
    .asm_addr(asm_addr), .asm_data(asm_data), .frame_ok(frame_ok), .frame_err(frame_err),
    .frame_ext(frame_ext), .frame_rtr(frame_rtr), .filter_match(filter_match),
    .rx_irq(rx_irq), .wm_irq(wm_irq), .capture_pulse(cap));
  // Event pulse counters and hang guard
  always @(posedge ref_clk) begin
    irq_n += (rx_irq === 1'b1);
    cap_n += (cap === 1'b1);
    wm_n += (wm_irq === 1'b1);
    cyc++;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    r = prdata;
    lerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    `CHK(r & m, e)
  endtask
  task automatic bufc(input int b, input int i, input logic [7:0] e);
    rdc(12'h100 + b * 12'h40 + i * 12'h4, 32'hff, {24'h0, e});
  endtask
  task automatic t_reset();
    rdc(`CRBM_OFF_CTRL, 32'hffffffff, 32'h0);
    rdc(`CRBM_OFF_STAT, 32'hffffffff, 32'h0);
    rdc(12'h01c, 32'hffffffff, 32'h0);
    `CHK(lerr, 1'b1)
    $display("test reset done");
  endtask
  task automatic t_fixed();
    wr(`CRBM_OFF_CTRL, 32'h28);
    i_crbm_engine_model.send(8'h10, 1'b0, 1'b1, 16'h0002);
    bufc(0, 0, 8'ha1);
    bufc(0, 2, 8'h11);
    i_crbm_engine_model.send(8'h40, 1'b0, 1'b0, 16'h0001);
    bufc(0, 13, 8'h1c);
    i_crbm_engine_model.send(8'h50, 1'b0, 1'b0, 16'h0004);
    bufc(1, 0, 8'h82);
    rdc(`CRBM_OFF_STAT, 32'hff, 32'h03);
    `CHK(irq_n, 2)
    `CHK(cap_n, 2)
    $display("test fixed done");
  endtask
  task automatic t_roll();
    wr(`CRBM_OFF_STAT, 32'hff);
    wr(`CRBM_OFF_CTRL, 32'h10);
    wr(`CRBM_OFF_FEXT, 32'h1);
    i_crbm_engine_model.send(8'h20, 1'b1, 1'b0, 16'h0001);
    i_crbm_engine_model.send(8'h30, 1'b1, 1'b0, 16'h0001);
    bufc(0, 2, 8'h29);
    bufc(0, 3, 8'h22);
    bufc(1, 0, 8'h86);
    bufc(1, 13, 8'h3c);
    `CHK(irq_n, 2)
    $display("test rollover done");
  endtask
  task automatic t_fifo();
    int k;
    wr(`CRBM_OFF_STAT, 32'hff);
    wr(`CRBM_OFF_TXSEL, 32'h08);
    wr(`CRBM_OFF_FEN, 32'hffff);
    wr(`CRBM_OFF_CTRL, 32'h02);
    for (k = 0; k < 4; k++) i_crbm_engine_model.send(8'h60 + k[7:0], 1'b1, 1'b0, 16'h0001);
    rdc(`CRBM_OFF_STAT, 32'h007f1fff, 32'h0040100f);
    `CHK(wm_n, 1)
    wr(`CRBM_OFF_STAT, 32'h01);
    rdc(`CRBM_OFF_STAT, 32'h000f00ff, 32'h0001000e);
    bufc(1, 0, 8'h80);
    bufc(3, 13, 8'h6f);
    $display("test fifo done");
  endtask
  task automatic t_flex();
    wr(`CRBM_OFF_STAT, 32'hff);
    wr(`CRBM_OFF_FEXT, 32'h0);
    wr(`CRBM_OFF_TXSEL, 32'h02);
    wr(`CRBM_OFF_FBUF0, 32'h132);
    wr(`CRBM_OFF_CTRL, 32'h01);
    i_crbm_engine_model.send(8'h70, 1'b0, 1'b0, 16'h0002);
    rdc(`CRBM_OFF_STAT, 32'hff, 32'h00);
    i_crbm_engine_model.send(8'h80, 1'b0, 1'b0, 16'h0005);
    bufc(1, 0, 8'h82);
    bufc(1, 5, 8'h84);
    rdc(`CRBM_OFF_STAT, 32'hff, 32'h02);
    $display("test flexible done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_fixed();
    t_roll();
    t_fifo();
    t_flex();
    close_out();
  end
endmodule // crbm_rx_buffer_manager_tb
